// ==== shared/nv_cmd_pkg.sv ====
// Purpose: constants for the non-volatile store/reload command block
// Assumes: 8-bit command codes arrive from a same-clock bus engine
// Notes: settings are 8 bits wide, four of them are backed up
// Contract
// - Command 0x11 copies every current setting into non-volatile memory.
// - Save-all takes about 50 ms; the host waits that long for the result.
// - Command 0x12 reloads every current setting from non-volatile memory.
// - Command 0x13 saves only the setting whose code equals the data byte.
// - Command 0x14 reloads only the setting whose code equals the data byte.
// - Reading 0x20 returns linear format with exponent minus ten.
// - The 0x20 value is constant and host writes leave it unchanged.
package nv_cmd_pkg;
  localparam logic [7:0] CMD_SAVE_ALL = 8'h11;
  localparam logic [7:0] CMD_LOAD_ALL = 8'h12;
  localparam logic [7:0] CMD_SAVE_ONE = 8'h13;
  localparam logic [7:0] CMD_LOAD_ONE = 8'h14;
  localparam logic [7:0] CMD_VOUT_FMT = 8'h20;
  // Linear mode 000, exponent -10 as 5-bit two's complement
  localparam logic [7:0] VOUT_FMT_VAL = 8'h16;
  localparam int NUM_SET = 4;
  localparam logic [1:0] LAST_IDX = 2'h3;
  localparam logic [7:0] SET0_CODE = 8'h01;
  localparam logic [7:0] SET1_CODE = 8'h02;
  localparam logic [7:0] SET2_CODE = 8'h21;
  localparam logic [7:0] SET3_CODE = 8'h22;
  localparam logic [7:0] SET_RST = 8'h00;
  localparam logic [1:0] IDX_RST = 2'h0;
  localparam logic [31:0] TMR_RST = 32'h0;
  localparam int unsigned SAVE_ALL_MS = 50;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SAVE_ALL_CYC = SAVE_ALL_MS * (CLK_HZ / 1000);

  // Bit 2 is the hit flag, bits 1:0 the setting index
  function automatic logic [2:0] code_index(input logic [7:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      SET0_CODE: r = 3'h4;
      SET1_CODE: r = 3'h5;
      SET2_CODE: r = 3'h6;
      SET3_CODE: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction
endpackage

// ==== rtl/nv_store.sv ====
// Purpose: small non-volatile backing store for the settings
// Assumes: one write port, one read port, registered read data
// Notes: cleared at reset so an unused word reads zero
`timescale 1ns/100ps
module nv_store
  import nv_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata_q
);
  logic [NUM_SET-1:0][7:0] mem_q;
  logic [NUM_SET-1:0][7:0] mem_d;
  logic [7:0] rdata_d;

  always_comb begin
    mem_d = mem_q;
    if (we) begin
      mem_d[waddr] = wdata;
    end
    rdata_d = mem_q[raddr];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= '0;
      rdata_q <= SET_RST;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end
endmodule

// ==== rtl/nv_cmd.sv ====
// Purpose: store/reload of settings to non-volatile memory by command code
// Assumes: command port driven by same-clock bus logic, one beat per command
// Notes: all commands are refused while a store or reload is running
`timescale 1ns/100ps
module nv_cmd
  import nv_cmd_pkg::*;
#(
  parameter int unsigned SAVE_ALL_CYCLES = SAVE_ALL_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rd_valid_q,
  output logic [7:0] rd_data_q,
  output logic busy,
  output logic [NUM_SET-1:0][7:0] settings_q
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SAVE, ST_WAIT, ST_RD, ST_LD
  } state_t;

  state_t state_q, state_d;
  logic [1:0] idx_q, idx_d;
  logic one_q, one_d;
  logic [31:0] tmr_q, tmr_d;
  logic [NUM_SET-1:0][7:0] settings_d;
  logic rd_valid_d;
  logic [7:0] rd_data_d;
  logic acc;
  logic [2:0] sel_hit;
  logic [2:0] reg_hit;
  logic nvm_we;
  logic [7:0] nvm_rdata;

  assign busy = (state_q != ST_IDLE);
  assign cmd_ready = !busy;
  assign acc = cmd_valid && cmd_ready;
  assign sel_hit = code_index(cmd_wdata);
  assign reg_hit = code_index(cmd_code);
  assign nvm_we = (state_q == ST_SAVE);

  ////////////////////////////////////////////////////////////////////////
  // Backing store

  nv_store u_store (
    .clk(clk),
    .reset_n(reset_n),
    .we(nvm_we),
    .waddr(idx_q),
    .wdata(settings_q[idx_q]),
    .raddr(idx_q),
    .rdata_q(nvm_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode and sequencer

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    one_d = one_q;
    tmr_d = tmr_q;
    settings_d = settings_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    case (state_q)
      ST_IDLE: begin
        if (acc && !cmd_write) begin
          rd_valid_d = 1'b1;
          if (cmd_code == CMD_VOUT_FMT) begin
            rd_data_d = VOUT_FMT_VAL;
          end else if (reg_hit[2]) begin
            rd_data_d = settings_q[reg_hit[1:0]];
          end else begin
            rd_data_d = 8'h00;
          end
        end else if (acc) begin
          case (cmd_code)
            CMD_SAVE_ALL: begin
              state_d = ST_SAVE;
              idx_d = IDX_RST;
              one_d = 1'b0;
            end
            CMD_LOAD_ALL: begin
              state_d = ST_RD;
              idx_d = IDX_RST;
              one_d = 1'b0;
            end
            CMD_SAVE_ONE: begin
              if (sel_hit[2]) begin
                state_d = ST_SAVE;
                idx_d = sel_hit[1:0];
                one_d = 1'b1;
              end
            end
            CMD_LOAD_ONE: begin
              if (sel_hit[2]) begin
                state_d = ST_RD;
                idx_d = sel_hit[1:0];
                one_d = 1'b1;
              end
            end
            CMD_VOUT_FMT: begin
              // Read-only format; write is dropped
              state_d = ST_IDLE;
            end
            default: begin
              if (reg_hit[2]) begin
                settings_d[reg_hit[1:0]] = cmd_wdata;
              end
            end
          endcase
        end
      end
      ST_SAVE: begin
        if (one_q) begin
          state_d = ST_IDLE;
        end else if (idx_q == LAST_IDX) begin
          state_d = ST_WAIT;
          tmr_d = TMR_RST;
        end else begin
          idx_d = idx_q + 2'h1;
        end
      end
      ST_WAIT: begin
        // Store commit time; busy until it has elapsed
        if (tmr_q >= SAVE_ALL_CYCLES - 1) begin
          state_d = ST_IDLE;
        end else begin
          tmr_d = tmr_q + 32'h1;
        end
      end
      ST_RD: begin
        state_d = ST_LD;
      end
      ST_LD: begin
        settings_d[idx_q] = nvm_rdata;
        if (one_q || idx_q == LAST_IDX) begin
          state_d = ST_IDLE;
        end else begin
          idx_d = idx_q + 2'h1;
          state_d = ST_RD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      idx_q <= IDX_RST;
      one_q <= 1'b0;
      tmr_q <= TMR_RST;
      settings_q <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q <= SET_RST;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      one_q <= one_d;
      tmr_q <= tmr_d;
      settings_q <= settings_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_save_all;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_SAVE_ALL |=> nvm_we [*4];
  endproperty
  a_save_all: assert property (p_save_all)
    else $error("save-all did not write every setting");

  property p_save_busy;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_SAVE_ALL |=> busy [*8];
  endproperty
  a_save_busy: assert property (p_save_busy)
    else $error("save-all ended early");

  property p_load_all;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_LOAD_ALL |=>
      busy ##[1:10] !busy;
  endproperty
  a_load_all: assert property (p_load_all)
    else $error("reload-all did not complete in time");

  property p_save_one;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_SAVE_ONE && sel_hit[2] |=>
      nvm_we && {1'b1, idx_q} == code_index($past(cmd_wdata)) ##1 !nvm_we;
  endproperty
  a_save_one: assert property (p_save_one)
    else $error("save-one wrote the wrong word");

  property p_load_one;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_LOAD_ONE && sel_hit[2] |->
      ##2 state_q == ST_LD ##1 !busy &&
      settings_q[idx_q] == $past(nvm_rdata);
  endproperty
  a_load_one: assert property (p_load_one)
    else $error("reload-one did not restore the setting");

  property p_vout_read;
    @(posedge clk) disable iff (!reset_n)
    acc && !cmd_write && cmd_code == CMD_VOUT_FMT |=>
      rd_valid_q && rd_data_q == 8'h16;
  endproperty
  a_vout_read: assert property (p_vout_read)
    else $error("format read returned a wrong value");

  property p_vout_const;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && cmd_code == CMD_VOUT_FMT |=>
      $stable(settings_q) && !busy;
  endproperty
  a_vout_const: assert property (p_vout_const)
    else $error("format write had an effect");

  property p_bad_sel;
    @(posedge clk) disable iff (!reset_n)
    acc && cmd_write && !sel_hit[2] &&
      (cmd_code == CMD_SAVE_ONE || cmd_code == CMD_LOAD_ONE) |=>
      !busy && !nvm_we && $stable(settings_q);
  endproperty
  a_bad_sel: assert property (p_bad_sel)
    else $error("unsupported selector changed state");
endmodule

// ==== test/host_model.sv ====
// Purpose: management bus host issuing one command beat at a time
// Assumes: beat taken on a rising edge with cmd_ready high
// Notes: released code and data lines show the inverse of the last value
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic rd_valid_q,
  input wire logic [7:0] rd_data_q,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end

  task automatic send(input logic w, input logic [7:0] c,
                      input logic [7:0] d, output logic [7:0] rd);
    int n;
    n = 0;
    rd = 8'hXX;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(negedge clk);
    // Hold the beat until an edge finds the block ready
    while (cmd_ready !== 1'b1 && n < 100000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    @(negedge clk);
    if (!w && rd_valid_q === 1'b1) rd = rd_data_q;
  endtask
endmodule

// ==== test/nv_cmd_tb.sv ====
// Purpose: self-checking bench for the store/reload command block
// Assumes: shortened save-all wait through SAVE_ALL_CYCLES
// Notes: random setting values from a fixed seed
`timescale 1ns/100ps
module nv_cmd_tb;
  import nv_cmd_pkg::*;
  localparam int unsigned SA = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_ready, rd_valid_q, busy;
  logic [7:0] cmd_code, cmd_wdata, rd_data_q, rd;
  logic [NUM_SET-1:0][7:0] settings_q;
  logic [7:0] codes [NUM_SET] = '{SET0_CODE, SET1_CODE, SET2_CODE, SET3_CODE};
  logic [7:0] saved [NUM_SET];
  logic [7:0] exp_s [NUM_SET];
  integer seed = 32'h9B7A;
  int miscompares = 0;
  int n_checks = 0;
  int n;

  always #12.5 clk = ~clk;

  nv_cmd #(.SAVE_ALL_CYCLES(SA)) DUT (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .busy(busy), .settings_q(settings_q));

  host_model host (.clk(clk), .cmd_ready(cmd_ready), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // Linear mode field, then exponent -10 in five-bit two's complement
  function automatic logic [7:0] fmt_exp();
    logic [4:0] e;
    e = 5'(-10);
    return {3'h0, e};
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp_all();
    for (int i = 0; i < NUM_SET; i++) check("setting", settings_q[i], exp_s[i]);
  endtask

  task automatic write_all();
    for (int i = 0; i < NUM_SET; i++) begin
      exp_s[i] = 8'($random(seed));
      host.send(1'b1, codes[i], exp_s[i], rd);
    end
    cmp_all();
  endtask

  task automatic cmd_wait(input logic [7:0] c, input logic [7:0] d);
    host.send(1'b1, c, d, rd);
    // Every command sent here starts a store or reload
    check("ready_while_busy", {7'h00, cmd_ready}, 8'h00);
    n = 0;
    while (busy !== 1'b0 && n < 100000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < NUM_SET; i++) exp_s[i] = SET_RST;
    cmp_all();
    host.send(1'b0, CMD_VOUT_FMT, 8'h00, rd);
    check("vout_fmt", rd, fmt_exp());
    host.send(1'b1, CMD_VOUT_FMT, 8'($random(seed)), rd);
    host.send(1'b0, CMD_VOUT_FMT, 8'h00, rd);
    check("vout_fmt_after_write", rd, fmt_exp());
    write_all();
    saved = exp_s;
    cmd_wait(CMD_SAVE_ALL, 8'h00);
    check("save_all_wait", 8'(n >= SA), 8'h01);
    write_all();
    cmd_wait(CMD_LOAD_ALL, 8'h00);
    exp_s = saved;
    cmp_all();
    for (int k = 0; k < NUM_SET; k++) begin
      write_all();
      cmd_wait(CMD_SAVE_ONE, codes[k]);
      saved[k] = exp_s[k];
      write_all();
      cmd_wait(CMD_LOAD_ALL, 8'h00);
      exp_s = saved;
      cmp_all();
      write_all();
      cmd_wait(CMD_LOAD_ONE, codes[k]);
      exp_s[k] = saved[k];
      cmp_all();
      host.send(1'b0, codes[k], 8'h00, rd);
      check("read_back", rd, saved[k]);
    end
    write_all();
    host.send(1'b1, CMD_SAVE_ONE, 8'h55, rd);
    check("busy_bad_save", {7'h00, busy}, 8'h00);
    host.send(1'b1, CMD_LOAD_ONE, 8'h20, rd);
    check("busy_bad_load", {7'h00, busy}, 8'h00);
    cmp_all();
    cmd_wait(CMD_LOAD_ALL, 8'h00);
    exp_s = saved;
    cmp_all();
    end_of_test();
  end
endmodule
